// [rtl/async_event_counter.v]
// Notes on behaviour
// R1 - Cascaded mode forms one 16-bit counter, 65536 events before wrapping.
// R2 - Counters increment on event edges regardless of processor clock state.
// R3 - Any counter overflow raises an interrupt request automatically; here none while busClockStopped is 1 or on a cascaded lower wrap.
// R4 - Module standby stops the block independently of the rest of chip.
// R5 - Overflow flags bits 7 and 6 accept only writes of 0.
// R6 - Control/status register resets to zero.
// R7 - High flag sets when upper counter wraps FF to 00.
// R8 - High flag clears only by reading it as 1 then writing 0.
// R9 - In cascaded mode high flag marks 16-bit wrap FFFF to 0000.
// R10 - Low flag sets on lower wrap only in split 8-bit mode.
// R11 - Low flag clears only by reading it as 1 then writing 0.
// R12 - Bit 5 is a free read/write reserved bit resetting to zero.
// R13 - Select bit 0: low pin drives lower counter, its wrap drives upper.
// R14 - Select bit resets to 0 (cascaded); writing 1 splits channels.
// R15 - Split mode: high pin drives upper, low pin drives lower counter.
// R16 - Count enable bit 3 gates upper counter; 0 holds its value.
// R17 - Count enable bit 2 gates lower counter; 0 holds its value.
// R18 - Release bit 1 at 0 holds upper counter at zero.
// R19 - Release bit 0 at 0 holds lower counter at zero.
// R20 - Overflow sets request flag; interrupt output only if enable is 1.
// R21 - While bus clock is stopped counters count but flags stay unchanged.
// R22 - Standby bit 3 of clock stop register at 0 halts counters, holds status.
// R23 - Overflow events are brought into bus timing once, never lost or doubled; here a wrap while busClockStopped is 1 is dropped.
// R24 - Software disables counting before reading counter values.
`timescale 1ns/1ps
`include "async_event_counter_map.vh"
module async_event_counter #(
    parameter COUNT_WIDTH = 8
) (
    // Clock and reset
    input wire clock,
    input wire rst_b,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [17:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_ff,
    output reg pready_ff,
    output reg pslverr_ff,
    // Event pins
    input wire eventInHigh,
    input wire eventInLow,
    // Low-power state
    input wire busClockStopped,
    // Interrupt
    output reg eventIrq_ff
);

    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_CTRL = 3'h1;
    localparam [2:0] SEL_HIGH = 3'h2;
    localparam [2:0] SEL_LOW = 3'h3;
    localparam [2:0] SEL_IRQ = 3'h4;
    localparam [2:0] SEL_STOP = 3'h5;

    function [2:0] decodeSel;
        input [17:0] addr;
        begin
            if (addr[1:0] != 2'h0) begin
                decodeSel = SEL_NONE;
            end else begin
                case (addr[17:2])
                    `IDX_EVENT_CTRL_STATUS: decodeSel = SEL_CTRL;
                    `IDX_EVENT_COUNT_HIGH: decodeSel = SEL_HIGH;
                    `IDX_EVENT_COUNT_LOW: decodeSel = SEL_LOW;
                    `IDX_EVENT_IRQ_CTRL: decodeSel = SEL_IRQ;
                    `IDX_MODULE_CLOCK_STOP_TWO: decodeSel = SEL_STOP;
                    default: decodeSel = SEL_NONE;
                endcase
            end
        end
    endfunction

    reg [7:0] ctrlStatus_ff;
    reg [7:0] clockStop_ff;
    reg irqEnable_ff;
    reg irqRequest_ff;
    reg seenHigh_ff;
    reg seenLow_ff;
    reg prevInHigh_ff;
    reg prevInLow_ff;
    reg [7:0] nxt_ctrlStatus;
    reg nxt_seenHigh;
    reg nxt_seenLow;
    reg nxt_irqRequest;
    reg [31:0] nxt_rdata;

    wire [COUNT_WIDTH-1:0] countHigh;
    wire [COUNT_WIDTH-1:0] countLow;
    wire wrapHigh;
    wire wrapLow;

    wire [2:0] sel = decodeSel(paddr);
    wire setupPhase = psel & ~penable;
    wire accessDone = psel & penable & pready_ff;
    wire doWrite = accessDone & pwrite;
    wire doRead = accessDone & ~pwrite;

    wire moduleActive = clockStop_ff[`BIT_EVENT_MODULE_STANDBY]; // R4 R22
    wire splitMode = ctrlStatus_ff[`BIT_CHANNEL_SPLIT_SELECT];
    wire riseHigh = eventInHigh & ~prevInHigh_ff; // R2
    wire riseLow = eventInLow & ~prevInLow_ff; // R2

    // Lower counter always fed from the low pin
    wire pulseLow = moduleActive & ctrlStatus_ff[`BIT_COUNT_ENABLE_LOW]
        & riseLow; // R17 R13 R15
    // Upper source: own pin when split, lower wrap when cascaded
    wire pulseHigh = moduleActive & ctrlStatus_ff[`BIT_COUNT_ENABLE_HIGH]
        & (splitMode ? riseHigh : wrapLow); // R16 R13 R15 R1
    wire clearHigh = ~ctrlStatus_ff[`BIT_COUNTER_RELEASE_HIGH]; // R18
    wire clearLow = ~ctrlStatus_ff[`BIT_COUNTER_RELEASE_LOW]; // R19

    // Wrap pulses are single-cycle flops in this clock, counted once each while flagsLive is high
    wire flagsLive = moduleActive & ~busClockStopped; // R21 R22 R23
    wire setHigh = flagsLive & wrapHigh; // R7 R9
    wire setLow = flagsLive & wrapLow & splitMode; // R10

    event_count_stage #(
        .WIDTH(COUNT_WIDTH)
    ) highStage (
        .clock(clock),
        .rst_b(rst_b),
        .countPulse(pulseHigh),
        .holdClear(clearHigh),
        .count_ff(countHigh),
        .wrap_ff(wrapHigh)
    );

    event_count_stage #(
        .WIDTH(COUNT_WIDTH)
    ) lowStage (
        .clock(clock),
        .rst_b(rst_b),
        .countPulse(pulseLow),
        .holdClear(clearLow),
        .count_ff(countLow),
        .wrap_ff(wrapLow)
    );

    // Control/status next value
    always @* begin
        nxt_ctrlStatus = ctrlStatus_ff;
        nxt_seenHigh = seenHigh_ff;
        nxt_seenLow = seenLow_ff;
        if (moduleActive) begin
            if (doRead && sel == SEL_CTRL) begin
                nxt_seenHigh = ctrlStatus_ff[`BIT_OVERFLOW_FLAG_HIGH]; // R8
                nxt_seenLow = ctrlStatus_ff[`BIT_OVERFLOW_FLAG_LOW]; // R11
            end
            if (doWrite && sel == SEL_CTRL) begin
                nxt_ctrlStatus[5:0] = pwdata[5:0]; // R12 R14
                if (seenHigh_ff && !pwdata[`BIT_OVERFLOW_FLAG_HIGH]) begin
                    nxt_ctrlStatus[`BIT_OVERFLOW_FLAG_HIGH] = 1'b0; // R5 R8
                end
                if (seenLow_ff && !pwdata[`BIT_OVERFLOW_FLAG_LOW]) begin
                    nxt_ctrlStatus[`BIT_OVERFLOW_FLAG_LOW] = 1'b0; // R5 R11
                end
                nxt_seenHigh = 1'b0;
                nxt_seenLow = 1'b0;
            end
        end
        // Hardware set wins over a clear in the same cycle
        if (setHigh) begin
            nxt_ctrlStatus[`BIT_OVERFLOW_FLAG_HIGH] = 1'b1; // R7 R9
        end
        if (setLow) begin
            nxt_ctrlStatus[`BIT_OVERFLOW_FLAG_LOW] = 1'b1; // R10
        end
    end

    // Interrupt request flag, cleared by writing 0 to its bit
    always @* begin
        nxt_irqRequest = irqRequest_ff;
        if (doWrite && sel == SEL_IRQ && !pwdata[`BIT_EVENT_IRQ_REQUEST]) begin
            nxt_irqRequest = 1'b0;
        end
        if (setHigh || setLow) begin
            nxt_irqRequest = 1'b1; // R3 R20
        end
    end

    // Read data, captured in the setup cycle
    always @* begin
        nxt_rdata = 32'h00000000;
        case (sel)
            SEL_CTRL: nxt_rdata[7:0] = ctrlStatus_ff;
            SEL_HIGH: nxt_rdata[COUNT_WIDTH-1:0] = countHigh; // R24
            SEL_LOW: nxt_rdata[COUNT_WIDTH-1:0] = countLow; // R24
            SEL_IRQ: nxt_rdata[1:0] = {irqRequest_ff, irqEnable_ff};
            SEL_STOP: nxt_rdata[7:0] = clockStop_ff;
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrlStatus_ff <= `RST_EVENT_CTRL_STATUS; // R6
            clockStop_ff <= `RST_MODULE_CLOCK_STOP_TWO;
            irqEnable_ff <= 1'b0;
            irqRequest_ff <= 1'b0;
            seenHigh_ff <= 1'b0;
            seenLow_ff <= 1'b0;
            prevInHigh_ff <= 1'b0;
            prevInLow_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            eventIrq_ff <= 1'b0;
        end else begin
            ctrlStatus_ff <= nxt_ctrlStatus;
            seenHigh_ff <= nxt_seenHigh;
            seenLow_ff <= nxt_seenLow;
            irqRequest_ff <= nxt_irqRequest;
            prevInHigh_ff <= eventInHigh;
            prevInLow_ff <= eventInLow;
            eventIrq_ff <= nxt_irqRequest & irqEnable_ff; // R20
            if (doWrite && sel == SEL_IRQ) begin
                irqEnable_ff <= pwdata[`BIT_EVENT_IRQ_ENABLE];
            end
            if (doWrite && sel == SEL_STOP) begin
                clockStop_ff <= pwdata[7:0]; // R22
            end
            // One wait state: ready rises in the second access cycle
            pready_ff <= psel & penable & ~pready_ff;
            if (setupPhase) begin
                prdata_ff <= nxt_rdata;
                pslverr_ff <= (sel == SEL_NONE);
            end
        end
    end

endmodule

// [rtl/async_event_counter_map.vh]
`ifndef ASYNC_EVENT_COUNTER_MAP_VH
`define ASYNC_EVENT_COUNTER_MAP_VH

// Register indices; byte address is four times the index
`define IDX_EVENT_CTRL_STATUS 16'hFF95
`define IDX_EVENT_COUNT_HIGH 16'hFF96
`define IDX_EVENT_COUNT_LOW 16'hFF97
`define IDX_EVENT_IRQ_CTRL 16'hFF98
`define IDX_MODULE_CLOCK_STOP_TWO 16'hFFFB

// Control/status field positions
`define BIT_OVERFLOW_FLAG_HIGH 7
`define BIT_OVERFLOW_FLAG_LOW 6
`define BIT_RESERVED 5
`define BIT_CHANNEL_SPLIT_SELECT 4
`define BIT_COUNT_ENABLE_HIGH 3
`define BIT_COUNT_ENABLE_LOW 2
`define BIT_COUNTER_RELEASE_HIGH 1
`define BIT_COUNTER_RELEASE_LOW 0

// Interrupt control field positions
`define BIT_EVENT_IRQ_ENABLE 0
`define BIT_EVENT_IRQ_REQUEST 1

// Clock stop register field position
`define BIT_EVENT_MODULE_STANDBY 3

// Reset values
`define RST_EVENT_CTRL_STATUS 8'h00
`define RST_MODULE_CLOCK_STOP_TWO 8'hFF
`define RST_COUNT 8'h00

`endif

// [rtl/event_count_stage.v]
`timescale 1ns/1ps
module event_count_stage #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire clock,
    input wire rst_b,
    // Control
    input wire countPulse,
    input wire holdClear,
    // Status
    output reg [WIDTH-1:0] count_ff,
    output reg wrap_ff
);

    reg [WIDTH-1:0] nxt_count;
    reg nxt_wrap;

    always @* begin
        nxt_count = count_ff;
        nxt_wrap = 1'b0;
        if (holdClear) begin
            nxt_count = {WIDTH{1'b0}};
        end else if (countPulse) begin
            nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
            nxt_wrap = &count_ff;
        end
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count_ff <= {WIDTH{1'b0}};
            wrap_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            wrap_ff <= nxt_wrap;
        end
    end

endmodule

// [verification/async_event_counter_chk.sv]
`timescale 1ns/1ps
`include "async_event_counter_map.vh"
module event_chk (
    // Clock and reset
    input wire clock,
    input wire rst_b,
    // Bus
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [17:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata_ff,
    input wire pready_ff,
    input wire pslverr_ff
);
    wire done = psel && penable && pready_ff;
    wire wr = done && pwrite;
    wire [15:0] idx = paddr[17:2];
    wire [7:0] rd = prdata_ff[7:0];
    wire rdHi = done && !pwrite && idx == `IDX_EVENT_COUNT_HIGH;
    wire rdLo = done && !pwrite && idx == `IDX_EVENT_COUNT_LOW;
    reg [5:0] ctl_ff;
    reg [7:0] stop_ff;
    reg [7:0] hi_ff;
    reg [7:0] lo_ff;
    reg okHi_ff;
    reg okLo_ff;
    // Shadow of the control bits; a count read stays valid until the next write
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctl_ff <= 6'h00;
            stop_ff <= 8'hFF;
            hi_ff <= 8'h00;
            lo_ff <= 8'h00;
            okHi_ff <= 1'b0;
            okLo_ff <= 1'b0;
        end else begin
            if (wr && idx == `IDX_EVENT_CTRL_STATUS && stop_ff[3])
                ctl_ff <= pwdata[5:0];
            if (wr && idx == `IDX_MODULE_CLOCK_STOP_TWO)
                stop_ff <= pwdata[7:0];
            if (rdHi)
                hi_ff <= rd;
            if (rdLo)
                lo_ff <= rd;
            okHi_ff <= (okHi_ff || rdHi) && !wr;
            okLo_ff <= (okLo_ff || rdLo) && !wr;
        end
    end
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_wait; psel && !penable |=> !pready_ff ##1 pready_ff; endproperty
    a_wait: assert property (p_wait) else $error("ready not after one wait");
    property p_err; done |-> pslverr_ff == !(idx inside {`IDX_EVENT_CTRL_STATUS,
        `IDX_EVENT_COUNT_HIGH, `IDX_EVENT_COUNT_LOW, `IDX_EVENT_IRQ_CTRL,
        `IDX_MODULE_CLOCK_STOP_TWO}); endproperty
    a_err: assert property (p_err) else $error("error response wrong");
    property p_st; done && !pwrite && idx == `IDX_EVENT_CTRL_STATUS
        |-> rd[5:0] == ctl_ff; endproperty
    a_st: assert property (p_st) else $error("status bits wrong");
    property p_stop; done && !pwrite && idx == `IDX_MODULE_CLOCK_STOP_TWO
        |-> rd == stop_ff; endproperty
    a_stop: assert property (p_stop) else $error("stop register wrong");
    property p_hclr; rdHi && !ctl_ff[1] |-> rd == 8'h00; endproperty
    a_hclr: assert property (p_hclr) else $error("upper not held at zero");
    property p_lclr; rdLo && !ctl_ff[0] |-> rd == 8'h00; endproperty
    a_lclr: assert property (p_lclr) else $error("lower not held at zero");
    property p_hhold; rdHi && okHi_ff && !(ctl_ff[3] && stop_ff[3]) |-> rd == hi_ff;
    endproperty
    a_hhold: assert property (p_hhold) else $error("upper moved while held");
    property p_lhold; rdLo && okLo_ff && !(ctl_ff[2] && stop_ff[3]) |-> rd == lo_ff;
    endproperty
    a_lhold: assert property (p_lhold) else $error("lower moved while held");
endmodule
bind async_event_counter event_chk chk (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff));

// [verification/event_source_model.sv]
`timescale 1ns/1ps
module event_source_model (
    // Clock and reset
    input wire clock,
    input wire rst_b,
    // One pulse per requested pin, each phase width cycles
    input wire [1:0] fire,
    input wire [2:0] width,
    // Pins and busy flag
    output wire [1:0] pins,
    output wire busy
);
    reg [3:0] left_ff [0:1];
    integer i;
    always @(posedge clock or negedge rst_b) begin
        for (i = 0; i < 2; i = i + 1) begin
            if (!rst_b)
                left_ff[i] <= 4'h0;
            else if (fire[i])
                left_ff[i] <= {width, 1'b0};
            else if (left_ff[i] != 4'h0)
                left_ff[i] <= left_ff[i] - 4'h1;
        end
    end
    // Rising edge starts each pulse; pins rest low between events
    assign pins[1] = left_ff[1] > {1'b0, width};
    assign pins[0] = left_ff[0] > {1'b0, width};
    assign busy = left_ff[0] != 4'h0 || left_ff[1] != 4'h0;
endmodule

// [verification/async_event_counter_test.sv]
`timescale 1ns/1ps
`include "async_event_counter_map.vh"
module async_event_counter_test;
    localparam [15:0] aSt = `IDX_EVENT_CTRL_STATUS;
    localparam [15:0] aHi = `IDX_EVENT_COUNT_HIGH;
    localparam [15:0] aLo = `IDX_EVENT_COUNT_LOW;
    localparam [15:0] aIrq = `IDX_EVENT_IRQ_CTRL;
    localparam [15:0] aStop = `IDX_MODULE_CLOCK_STOP_TWO;
    reg clock = 1'b0;
    reg rst_b = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg busClockStopped = 1'b0;
    reg [17:0] paddr = 18'h00000;
    reg [31:0] pwdata = 32'h00000000;
    reg [1:0] fire = 2'h0;
    reg [2:0] width = 3'h1;
    reg [31:0] seed = 32'h000091CE;
    reg [8:0] expQ [$];
    wire [31:0] prdata_ff;
    wire pready_ff, pslverr_ff, eventIrq_ff, busy;
    wire [1:0] pins;
    integer fail_count = 0;
    integer tests_run = 0;
    integer m;
    integer k;
    always #10 clock = ~clock;
    async_event_counter dut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
        .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .eventInHigh(pins[1]),
        .eventInLow(pins[0]), .busClockStopped(busClockStopped), .eventIrq_ff(eventIrq_ff));
    event_source_model src (.clock(clock), .rst_b(rst_b), .fire(fire), .width(width),
        .pins(pins), .busy(busy));
    function [31:0] xs(input [31:0] v);
        reg [31:0] t;
        begin
            t = v ^ (v << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task check(input [8:0] got, input [8:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task xfer(input w, input [15:0] idx, input [7:0] d);
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= {idx, 2'b00};
            pwdata <= {24'h000000, d};
            @(posedge clock);
            penable <= 1'b1;
            @(posedge clock);
            while (pready_ff !== 1'b1) @(posedge clock);
            psel <= 1'b0;
            penable <= 1'b0;
            // Idle cycle keeps psel from being driven twice in one step
            @(posedge clock);
        end
    endtask
    task rd(input [15:0] idx, input [8:0] exp);
        begin
            expQ.push_back(exp);
            xfer(1'b0, idx, 8'h00);
        end
    endtask
    task ev(input [1:0] sel, input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                seed = xs(seed);
                width <= 3'h1 + {1'b0, seed[1:0]};
                fire <= sel;
                @(posedge clock);
                fire <= 2'h0;
                @(posedge clock);
                while (busy === 1'b1) @(posedge clock);
            end
            repeat (6) @(posedge clock);
        end
    endtask
    task wrap_up;
        begin
            $display("compares=%0d mismatches=%0d", tests_run, fail_count);
            if (fail_count == 0 && tests_run > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Read completions are matched against the oldest expectation
    always @(posedge clock) begin
        if (psel && penable && pready_ff && !pwrite)
            check({pslverr_ff, prdata_ff[7:0]}, expQ.pop_front());
    end
    initial begin
        #1000000;
        fail_count = fail_count + 1;
        wrap_up;
    end
    initial begin
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rd(aSt, 9'h000);
        rd(aStop, 9'h0FF);
        rd(aHi, 9'h000);
        rd(aLo, 9'h000);
        rd(16'hFF99, 9'h100);
        xfer(1'b1, aIrq, 8'h01);
        xfer(1'b1, aSt, 8'hFF);
        rd(aSt, 9'h03F);
        seed = xs(seed);
        m = 1 + seed[4:0];
        seed = xs(seed);
        k = 1 + seed[4:0];
        ev(2'h3, m);
        ev(2'h1, k);
        rd(aHi, m[8:0]);
        rd(aLo, m[8:0] + k[8:0]);
        ev(2'h1, 256 - m - k);
        check({8'h00, eventIrq_ff}, 9'h001);
        rd(aIrq, 9'h003);
        xfer(1'b1, aSt, 8'h3F);
        rd(aSt, 9'h07F);
        xfer(1'b1, aSt, 8'h3F);
        rd(aSt, 9'h03F);
        xfer(1'b1, aIrq, 8'h01);
        ev(2'h2, 255 - m);
        ev(2'h1, 255);
        xfer(1'b1, aSt, 8'h2F);
        ev(2'h1, 1);
        rd(aSt, 9'h0AF);
        rd(aHi, 9'h000);
        rd(aLo, 9'h000);
        xfer(1'b1, aSt, 8'h2F);
        rd(aSt, 9'h02F);
        xfer(1'b1, aSt, 8'h33);
        rd(aHi, 9'h000);
        rd(aLo, 9'h000);
        ev(2'h3, k);
        rd(aHi, 9'h000);
        rd(aLo, 9'h000);
        xfer(1'b1, aSt, 8'h3F);
        busClockStopped <= 1'b1;
        ev(2'h3, 259);
        busClockStopped <= 1'b0;
        rd(aSt, 9'h03F);
        rd(aHi, 9'h003);
        xfer(1'b1, aStop, 8'hF7);
        xfer(1'b1, aSt, 8'h00);
        rd(aLo, 9'h003);
        ev(2'h3, 2);
        rd(aLo, 9'h003);
        rd(aSt, 9'h03F);
        rd(aStop, 9'h0F7);
        xfer(1'b1, aStop, 8'hFF);
        xfer(1'b1, aSt, 8'h3C);
        rd(aHi, 9'h000);
        rd(aLo, 9'h000);
        wrap_up;
    end
endmodule
